// file: hw/iso_rx_pkg.sv
// Constants for the isochronous dual-packet receive status block
package iso_rx_pkg;
   // Fill-state encodings
   localparam logic [1:0] FILL_EMPTY = 2'h0;
   localparam logic [1:0] FILL_ONE_A = 2'h1;
   localparam logic [1:0] FILL_ONE_B = 2'h2;
   localparam logic [1:0] FILL_FULL = 2'h3;
   // Reset values
   localparam logic [1:0] FILL_RESET = 2'h0;
   localparam logic FLAG_RESET = 1'b0;
   // Transaction outcome codes
   typedef enum logic [2:0] {
      OUT_NONE = 3'b000,
      OUT_GOOD = 3'b001,
      OUT_DATA_ERR = 3'b010,
      OUT_FIFO_ERR = 3'b011,
      OUT_TIMEOUT = 3'b100
   } out_result_t;
endpackage : iso_rx_pkg

// file: hw/iso_rx_dual_packet_fifo_status.sv
// Isochronous dual-packet receive FIFO fill, overrun, underrun and transaction flags
// Notes on behaviour
// - Overrun and underrun are sticky; only firmware clear inputs lower them.
// - Data-flow updates happen only while endpoint enable and armed are both set.
// - Firmware changes act at once; bus changes to fill and overrun wait for the next SOF.
// - Firmware reading an empty FIFO sets underrun immediately.
// - Overrun seen in a transaction shows in the flag at the next SOF.
// - Read-complete lowers the fill state immediately by one packet.
// - Good reception raises the visible fill state only at the next SOF.
// - Error, acknowledge and void flags update when each transaction ends, except a timeout on an accepted token.
// - Good packet with one held: pending fill 11, ack set, err/void clear, advance.
// - No handshake is ever returned and no receive interrupt is raised.
`timescale 1ns/1ps
module iso_rx_dual_packet_fifo_status
   import iso_rx_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk_in,
   input wire logic sys_rst_in,
   // Endpoint configuration
   input wire logic rx_endpoint_enable_in,
   input wire logic rx_armed_in,
   input wire logic rx_input_enable_in,
   // Bus-side events from the serial engine
   input wire logic sof_in,
   input wire logic out_done_in,
   input wire logic [2:0] out_result_in,
   // Firmware-side events
   input wire logic fifo_read_in,
   input wire logic rx_read_complete_in,
   input wire logic clr_overrun_in,
   input wire logic clr_underrun_in,
   // Status outputs
   output logic [1:0] rx_fill_state_out,
   output logic rx_overrun_flag_out,
   output logic rx_underrun_flag_out,
   output logic rx_error_flag_out,
   output logic rx_acknowledge_flag_out,
   output logic rx_void_flag_out,
   output logic write_advance_out,
   output logic write_reverse_out,
   output logic handshake_send_out,
   output logic rx_interrupt_out
);

   // Visible and pending state
   logic [1:0] fill_q;
   logic pend_pkts_q;
   logic [1:0] pend_cnt_q;
   logic ovf_q;
   logic ovf_pend_q;
   logic urf_q;
   logic err_q;
   logic ack_q;
   logic void_q;
   logic adv_q;
   logic rev_q;

   // Packets shown by a fill code, not counting ones already taken but not yet shown
   function automatic logic [1:0] pkt_count(input logic [1:0] f);
      pkt_count = (f == FILL_FULL) ? 2'h2 : ((f == FILL_EMPTY) ? 2'h0 : 2'h1);
   endfunction : pkt_count

   function automatic logic [1:0] count_to_fill(input logic [1:0] c);
      count_to_fill = (c >= 2'h2) ? FILL_FULL : ((c == 2'h1) ? FILL_ONE_A : FILL_EMPTY);
   endfunction : count_to_fill

   logic active;
   logic [1:0] held;
   logic fifo_err_pending;
   logic token_void;
   out_result_t res;

   assign active = rx_endpoint_enable_in & rx_armed_in;
   assign res = out_result_t'(out_result_in);
   // Shown plus pending never passes two, so the carry is dropped on purpose
   assign held = 2'(pkt_count(fill_q) + pend_cnt_q);
   // Error already present blocks new data until firmware clears it
   assign fifo_err_pending = ovf_q | ovf_pend_q | urf_q;
   assign token_void = ~rx_input_enable_in | fifo_err_pending | (held >= 2'h2);

   // Firmware drop and bus gain for this cycle; the gain waits in pend_cnt_q for SOF
   logic [1:0] base_cnt;
   logic [1:0] pend_cnt_d;
   logic [1:0] fill_d;
   logic read_done;
   logic pkt_taken;

   // Read-complete on an empty FIFO has nothing to drop
   assign read_done = rx_read_complete_in & (pkt_count(fill_q) != 2'h0);
   // Timed-out or void tokens load nothing; bad data still occupies a slot
   assign pkt_taken = out_done_in & ~token_void & (res != OUT_TIMEOUT) & (res != OUT_NONE);

   always_comb begin
      base_cnt = pkt_count(fill_q);
      pend_cnt_d = pend_cnt_q;
      if (read_done) begin
         base_cnt = 2'(base_cnt - 2'h1);
      end
      if (pkt_taken) begin
         pend_cnt_d = 2'(pend_cnt_d + 2'h1); // Counted toward next frame's fill
      end
      // Read-complete in the SOF cycle: drop first, then add what the frame brought
      if (sof_in) begin
         fill_d = count_to_fill(2'(base_cnt + pend_cnt_d));
         pend_cnt_d = 2'h0;
      end else begin
         fill_d = count_to_fill(base_cnt);
      end
   end

   // Fill register; nothing moves while the endpoint is off or disarmed
   always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         fill_q <= FILL_RESET;
         pend_cnt_q <= 2'h0;
      end else if (active) begin
         fill_q <= fill_d;
         pend_cnt_q <= pend_cnt_d;
      end
   end

   // Overrun caught in a transaction waits in ovf_pend_q; only SOF publishes it
   logic ovf_seen;
   logic ovf_pend_d;
   logic ovf_d;

   assign ovf_seen = active & out_done_in & ~token_void & (res == OUT_FIFO_ERR);

   always_comb begin
      ovf_pend_d = ovf_pend_q | ovf_seen;
      ovf_d = ovf_q & ~clr_overrun_in;
      // Clear is ignored in the publishing cycle so a fresh overrun is never lost
      if (active && sof_in) begin
         ovf_d = ovf_q | ovf_pend_d;
         ovf_pend_d = 1'h0;
      end
   end

   // Sticky overrun register
   always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         ovf_q <= FLAG_RESET;
         ovf_pend_q <= FLAG_RESET;
      end else begin
         ovf_q <= ovf_d;
         ovf_pend_q <= ovf_pend_d;
      end
   end

   // Underrun: firmware caused, immediate; set beats clear
   always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         urf_q <= FLAG_RESET;
      end else if (active && fifo_read_in && pkt_count(fill_q) == 2'h0) begin
         urf_q <= 1'b1;
      end else if (clr_underrun_in) begin
         urf_q <= 1'b0;
      end
   end

   // Transaction flags updated at end of each transaction, except a timeout on an accepted token
   always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         err_q <= FLAG_RESET;
         ack_q <= FLAG_RESET;
         void_q <= FLAG_RESET;
      end else if (active && out_done_in && res != OUT_NONE) begin
         if (token_void) begin
            void_q <= 1'b1;
         end else begin
            case (res)
               OUT_GOOD: begin
                  err_q <= 1'b0;
                  ack_q <= 1'b1;
                  void_q <= 1'b0;
               end
               OUT_DATA_ERR, OUT_FIFO_ERR: begin
                  err_q <= 1'b1;
                  ack_q <= 1'b0;
                  void_q <= 1'b0;
               end
               default: begin
               end
            endcase
         end
      end
   end

   // Write marker strobes, one cycle each
   always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         adv_q <= 1'b0;
         rev_q <= 1'b0;
      end else begin
         adv_q <= active & out_done_in & ~token_void & (res == OUT_GOOD);
         rev_q <= active & out_done_in & ~token_void & (res == OUT_DATA_ERR);
      end
   end

   assign rx_fill_state_out = fill_q;
   assign rx_overrun_flag_out = ovf_q;
   assign rx_underrun_flag_out = urf_q;
   assign rx_error_flag_out = err_q;
   assign rx_acknowledge_flag_out = ack_q;
   assign rx_void_flag_out = void_q;
   assign write_advance_out = adv_q;
   assign write_reverse_out = rev_q;
   // Isochronous: never handshake, never interrupt
   assign handshake_send_out = 1'b0;
   assign rx_interrupt_out = 1'b0;

   // Checks
   urf_now_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
      active && fifo_read_in && fill_q == FILL_EMPTY |=> urf_q)
      else $error("underrun not set on empty read");
   urf_sticky_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
      urf_q && !clr_underrun_in |=> urf_q)
      else $error("underrun cleared without firmware");
   ovf_sticky_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
      ovf_q && !clr_overrun_in |=> ovf_q)
      else $error("overrun cleared without firmware");
   ovf_wait_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
      !ovf_q && !sof_in |=> !ovf_q)
      else $error("overrun set outside SOF");
   fill_rise_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
      !sof_in |=> pkt_count(fill_q) <= pkt_count($past(fill_q)))
      else $error("fill rose outside SOF");
   fill_drop_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
      active && rx_read_complete_in && !sof_in && fill_q != FILL_EMPTY
      |=> pkt_count(fill_q) == pkt_count($past(fill_q)) - 2'h1)
      else $error("read complete did not lower fill");
   good_ack_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
      active && out_done_in && !token_void && res == OUT_GOOD |=> ack_q && !err_q && !void_q && adv_q)
      else $error("good packet flags wrong");
   void_only_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
      active && out_done_in && token_void && res != OUT_NONE && !sof_in
      |=> void_q && !adv_q && !rev_q && $stable(pend_cnt_q))
      else $error("void token changed FIFO");
   bad_data_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
      active && out_done_in && !token_void && res == OUT_DATA_ERR |=> err_q && !ack_q && rev_q)
      else $error("data error flags wrong");
   idle_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
      !active |=> $stable(fill_q) && $stable(err_q))
      else $error("state moved while disabled");
   no_hs_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
      !handshake_send_out && !rx_interrupt_out)
      else $error("handshake or interrupt raised");

   // Frame publishing: pending work lands at SOF and nowhere else
   ovf_publish_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
      active && sof_in && ovf_pend_q |=> ovf_q)
      else $error("pending overrun not published at SOF");
   ovf_pend_hold_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
      ovf_pend_q && !(active && sof_in) |=> ovf_pend_q)
      else $error("pending overrun lost before SOF");
   pend_clear_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
      active && sof_in |=> pend_cnt_q == 2'h0)
      else $error("pending packets kept past SOF");
   fill_publish_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
      active && sof_in && fill_q == FILL_EMPTY && pend_cnt_q != 2'h0 |=> fill_q != FILL_EMPTY)
      else $error("SOF did not show pending packet");

   // Bus-caused flags and strobes move only at transaction end
   flags_quiet_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
      !out_done_in |=> $stable(err_q) && $stable(ack_q) && $stable(void_q))
      else $error("transaction flags moved without transaction");
   strobe_quiet_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
      !out_done_in |=> !adv_q && !rev_q)
      else $error("write marker strobe without transaction");
   timeout_keep_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
      active && out_done_in && !token_void && res == OUT_TIMEOUT && !sof_in
      |=> $stable(pend_cnt_q) && $stable(ack_q) && $stable(err_q) && $stable(void_q))
      else $error("timed-out transaction changed state");
   ack_err_excl_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
      !(ack_q && err_q))
      else $error("acknowledge and error both set");
   adv_rev_excl_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
      !(adv_q && rev_q))
      else $error("write marker advanced and reversed together");

   // Firmware-only underrun, refusal and capacity limits
   urf_fw_only_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
      !urf_q && !(active && fifo_read_in) |=> !urf_q)
      else $error("underrun set without firmware read");
   urf_idle_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
      !active && !clr_underrun_in |=> $stable(urf_q))
      else $error("underrun moved while disabled");
   void_cause_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
      !rx_input_enable_in || ovf_q || ovf_pend_q || urf_q |-> token_void)
      else $error("token accepted despite refusal");
   full_no_pend_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
      !(fill_q == FILL_FULL && pend_cnt_q != 2'h0))
      else $error("packet taken while full");
   one_code_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
      fill_q != FILL_ONE_B)
      else $error("one packet shown with wrong code");


   good_pkt_c: cover property (@(posedge ref_clk_in) disable iff (sys_rst_in)
      active && out_done_in && res == OUT_GOOD ##[1:50] sof_in);
   full_c: cover property (@(posedge ref_clk_in) disable iff (sys_rst_in) fill_q == FILL_FULL);
   underrun_c: cover property (@(posedge ref_clk_in) disable iff (sys_rst_in) $rose(urf_q));
   overrun_c: cover property (@(posedge ref_clk_in) disable iff (sys_rst_in) $rose(ovf_q));
   void_c: cover property (@(posedge ref_clk_in) disable iff (sys_rst_in) active && out_done_in && token_void);
endmodule : iso_rx_dual_packet_fifo_status

// file: dv/usb_host_model.sv
// Host-side model driving frame markers and OUT transaction outcomes
`timescale 1ns/1ps
module usb_host_model
   import iso_rx_pkg::*;
(
   // Clock
   input wire logic ref_clk_in,
   // Bus-side events
   output logic sof_out,
   output logic out_done_out,
   output logic [2:0] out_result_out
);
   // Quiet bus at start
   initial begin
      sof_out = 1'h0;
      out_done_out = 1'h0;
      out_result_out = 3'h7;
   end
   // Outcome inverted once done drops; FIFO-error and timeout codes invert into each other, so only done marks a code valid
   task automatic send_out(input out_result_t r);
      @(negedge ref_clk_in);
      out_done_out = 1'h1;
      out_result_out = r;
      @(negedge ref_clk_in);
      out_done_out = 1'h0;
      out_result_out = ~r;
   endtask : send_out
   // One-cycle frame marker
   task automatic send_sof();
      @(negedge ref_clk_in);
      sof_out = 1'h1;
      @(negedge ref_clk_in);
      sof_out = 1'h0;
   endtask : send_sof
endmodule : usb_host_model

// file: dv/iso_rx_dual_packet_fifo_status_tb.sv
// Self-checking bench for the isochronous receive status block
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin mismatches++; $display("mismatch %0t %h %h", $time, a, b); end end
module iso_rx_dual_packet_fifo_status_tb;
   import iso_rx_pkg::*;
   logic ref_clk_in = 1'h0;
   logic sys_rst_in = 1'h1;
   logic en = 1'h1, arm = 1'h1, ie = 1'h1;
   logic [3:0] fw = 4'h0;
   logic sof, done;
   logic [2:0] res;
   logic [1:0] fill;
   logic ovf, urf, err, ack, vd, adv, rev, hs, irq;
   int mismatches = 0, checks = 0, cycles = 0;
   usb_host_model host_u (.ref_clk_in(ref_clk_in), .sof_out(sof), .out_done_out(done), .out_result_out(res));
   iso_rx_dual_packet_fifo_status dut_u (.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in),
      .rx_endpoint_enable_in(en), .rx_armed_in(arm), .rx_input_enable_in(ie), .sof_in(sof),
      .out_done_in(done), .out_result_in(res), .fifo_read_in(fw[3]), .rx_read_complete_in(fw[2]),
      .clr_overrun_in(fw[1]), .clr_underrun_in(fw[0]), .rx_fill_state_out(fill), .rx_overrun_flag_out(ovf),
      .rx_underrun_flag_out(urf), .rx_error_flag_out(err), .rx_acknowledge_flag_out(ack),
      .rx_void_flag_out(vd), .write_advance_out(adv), .write_reverse_out(rev), .handshake_send_out(hs),
      .rx_interrupt_out(irq));
   // Free-running 10 MHz clock
   initial begin
      forever #50 ref_clk_in = ~ref_clk_in;
   end
   // Hang guard, far above the roughly 70 cycles the tests need
   always @(posedge ref_clk_in) begin
      cycles++;
      if (cycles == 3000) begin
         mismatches++;
         print_verdict();
      end
   end
   // Firmware strobes: read, read-complete, clear overrun, clear underrun
   task automatic fw_pulse(input logic [3:0] m);
      @(negedge ref_clk_in);
      fw = m;
      @(negedge ref_clk_in);
      fw = 4'h0;
   endtask : fw_pulse
   task automatic t_void_disabled();
      ie = 1'h0;
      host_u.send_out(OUT_GOOD);
      `CHK(vd, 1'h1)
      `CHK(ack, 1'h0)
      host_u.send_sof();
      `CHK(fill, FILL_EMPTY)
      ie = 1'h1;
   endtask : t_void_disabled
   // Timed-out data loads nothing, even across a frame
   task automatic t_timeout();
      host_u.send_out(OUT_TIMEOUT);
      `CHK(vd, 1'h1)
      `CHK(adv, 1'h0)
      host_u.send_sof();
      `CHK(fill, FILL_EMPTY)
   endtask : t_timeout
   task automatic t_good_fill();
      host_u.send_out(OUT_GOOD);
      `CHK(ack, 1'h1)
      `CHK(vd, 1'h0)
      `CHK(adv, 1'h1)
      `CHK(fill, FILL_EMPTY)
      host_u.send_sof();
      `CHK(fill, FILL_ONE_A)
      host_u.send_out(OUT_GOOD);
      `CHK(fill, FILL_ONE_A)
      host_u.send_sof();
      `CHK(fill, FILL_FULL)
   endtask : t_good_fill
   task automatic t_full_token();
      host_u.send_out(OUT_GOOD);
      `CHK(vd, 1'h1)
      `CHK(adv, 1'h0)
      host_u.send_sof();
      `CHK(fill, FILL_FULL)
   endtask : t_full_token
   // Read-complete acts without waiting for a frame
   task automatic t_read_complete();
      fw_pulse(4'hc);
      `CHK(fill, FILL_ONE_A)
      fw_pulse(4'hc);
      `CHK(fill, FILL_EMPTY)
   endtask : t_read_complete
   task automatic t_underrun();
      fw_pulse(4'h8);
      `CHK(urf, 1'h1)
      host_u.send_sof();
      `CHK(urf, 1'h1)
      fw_pulse(4'h1);
      `CHK(urf, 1'h0)
      fw_pulse(4'h9);
      `CHK(urf, 1'h1)
      fw_pulse(4'h1);
      `CHK(urf, 1'h0)
   endtask : t_underrun
   task automatic t_errors();
      host_u.send_out(OUT_DATA_ERR);
      `CHK({err, ack, vd, rev}, 4'h9)
      host_u.send_sof();
      `CHK(fill, FILL_ONE_A)
      host_u.send_out(OUT_FIFO_ERR);
      `CHK(err, 1'h1)
      `CHK(ovf, 1'h0)
      host_u.send_sof();
      `CHK(ovf, 1'h1)
      `CHK(fill, FILL_FULL)
      host_u.send_sof();
      `CHK(ovf, 1'h1)
      fw_pulse(4'h2);
      `CHK(ovf, 1'h0)
   endtask : t_errors
   // Disarmed endpoint must ignore read-complete; disabled endpoint must ignore the bus
   task automatic t_disarmed();
      arm = 1'h0;
      fw_pulse(4'hc);
      `CHK(fill, FILL_FULL)
      arm = 1'h1;
      en = 1'h0;
      host_u.send_out(OUT_GOOD);
      `CHK(ack, 1'h0)
      `CHK(vd, 1'h0)
      en = 1'h1;
      `CHK({hs, irq}, 2'h0)
   endtask : t_disarmed
   task automatic print_verdict();
      if (mismatches == 0 && checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : print_verdict
   // Reset for 20 cycles, then the scenarios in order of fill state
   initial begin
      repeat (20) @(posedge ref_clk_in);
      @(negedge ref_clk_in);
      sys_rst_in = 1'h0;
      t_void_disabled();
      t_timeout();
      t_good_fill();
      t_full_token();
      t_read_complete();
      t_underrun();
      t_errors();
      t_disarmed();
      print_verdict();
   end
endmodule : iso_rx_dual_packet_fifo_status_tb
